// File: core/smwp_defs.svh
// constants for the spi memory write-protect block
`ifndef SMWP_DEFS_SVH
`define SMWP_DEFS_SVH
`define SMWP_OP_SET_LATCH   8'h06
`define SMWP_OP_CLR_LATCH   8'h04
`define SMWP_OP_STAT_RD     8'h05
`define SMWP_OP_STAT_WR     8'h01
`define SMWP_OP_ARRAY_WR    8'h02
`define SMWP_OP_SPARE_WR    8'h42
`define SMWP_OP_SERIAL_WR   8'hc2
`define SMWP_OP_DEEP_SLEEP  8'hba
`define SMWP_OP_HIBERNATE   8'hb9
`define SMWP_BIT_BUSY       0
`define SMWP_BIT_LATCH      1
`define SMWP_BIT_GUARD_LO   2
`define SMWP_BIT_GUARD_HI   3
`define SMWP_BIT_PIN_EN     7
`define SMWP_STAT_FIXED     8'h40
`define SMWP_QTR_BASE       19'h60000
`define SMWP_HALF_BASE      19'h40000
`define SMWP_ADDR_BYTES     3'h3
`endif

// File: core/smwp_pkg.sv
// types shared by the spi memory write-protect block
`default_nettype none
package smwp_pkg;
   typedef enum logic [2:0] {
      SMWP_OPC  = 3'b000,
      SMWP_ADDR = 3'b001,
      SMWP_DATA = 3'b010,
      SMWP_STAT = 3'b011,
      SMWP_IDLE = 3'b100
   } smwp_phase_t;
   // one array or side write offered to the storage behind this block
   typedef struct packed {
      logic       valid;
      logic [1:0] target;
      logic [18:0] addr;
      logic [7:0] data;
   } smwp_wr_t;
   // nonvolatile guard bits handed to and from the storage
   typedef struct packed {
      logic       pin_en;
      logic [1:0] guard;
   } smwp_nv_t;
endpackage
`default_nettype wire

// File: core/smwp_core.sv
// write-enable latch and status write protection of a serial memory
// Functional notes
// (R01) latch is cleared after power-up, so no write is taken
// (R02) opcode 06h in its own frame sets the latch
// (R03) status, array, spare and serial writes need the latch set
// (R04) status write data never alters the latch flag; only 06h sets it
// (R05) frame end after 04h, 01h, 02h, 42h or c2h clears latch
// (R06) opcode 04h clears the latch and disables every write
// (R07) latch flag reads one when writes enabled, zero otherwise
// (R08) status bit 0 ignores writes and reads zero
// (R09) bit 0 may read one while waking from deep sleep or hibernate
// (R10) status bits 4 and 5 read zero always
// (R11) status bit 6 reads one always
// (R12) block-guard bits are nonvolatile and survive power cycles
// (R13) guard 00 none, 01 upper quarter, 10 upper half, 11 all
// (R14) guard pin never blocks array writes
// (R15) pin ignored while pin-guard enable is zero
// (R16) enable one and pin low rejects status writes
// (R17) status write 01h plus one byte changes only enable and guards
// (R18) status read 05h shifts out one status byte
// (R19) burst reaching a guarded address stops and drops later bytes
// (R20) rejected writes finish silently, output undriven
`include "smwp_defs.svh"
`default_nettype none
module smwp_core (
   // system
   input wire logic clk,
   input wire logic rst,
   // spi link, own clock
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   output logic so,
   output logic so_oe,
   input wire logic wp_n,
   // nonvolatile storage of the guard bits
   input wire smwp_pkg::smwp_nv_t nv_in,
   output smwp_pkg::smwp_nv_t nv_out,
   output logic nv_store,
   // wake state from the power controller
   input wire logic waking,
   // write offered to storage
   output smwp_pkg::smwp_wr_t wr_req,
   // status view
   output logic [7:0] status
);
   // link domain: byte shifter on rising sck, reset by cs_n high
   logic [2:0] bit_r;
   logic [7:0] sh_r;
   logic [7:0] op_r;
   logic [1:0] nab_r;
   logic [18:0] addr_r;
   logic stop_r;
   smwp_pkg::smwp_phase_t ph_r;
   logic [7:0] stat_snap;
   logic wr_tog_r;
   smwp_pkg::smwp_wr_t wr_lk_r;
   logic set_tog_r;
   logic clr_tog_r;
   logic sw_tog_r;
   logic [2:0] sw_data_r;
   logic [7:0] rd_sh_r;
   logic [7:0] nb;
   logic [18:0] wa;
   logic gprot;
   logic latch_lk1_r;
   logic latch_lk2_r;
   logic pinen_lk1_r;
   logic pinen_lk2_r;
   logic [1:0] grd_lk1_r;
   logic [1:0] grd_lk2_r;
   logic wp1_r;
   logic wp2_r;
   // system-side state, declared here because the link syncs read it
   logic latch_r;
   logic pin_en_r;
   logic [1:0] guard_r;
   assign nb = {sh_r[6:0], si};
   assign wa = addr_r;
   // guard decode on the address about to be written
   always_comb begin
      case (grd_lk2_r)
         2'b00: gprot = 1'b0;
         2'b01: gprot = (wa >= `SMWP_QTR_BASE);
         2'b10: gprot = (wa >= `SMWP_HALF_BASE);
         default: gprot = 1'b1; // R13
      endcase
   end
   // slow levels synchronised into the link clock
   always_ff @(posedge sck) begin
      latch_lk1_r <= latch_r;
      latch_lk2_r <= latch_lk1_r;
      pinen_lk1_r <= pin_en_r;
      pinen_lk2_r <= pinen_lk1_r;
      grd_lk1_r <= guard_r;
      grd_lk2_r <= grd_lk1_r;
      wp1_r <= wp_n;
      wp2_r <= wp1_r;
   end
   // frame logic; the async cs_n release restarts decoding each frame
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         bit_r <= 3'h0;
         sh_r <= 8'h00;
         ph_r <= smwp_pkg::SMWP_OPC;
         nab_r <= 2'h0;
         stop_r <= 1'b0;
      end else begin
         bit_r <= bit_r + 3'h1;
         sh_r <= nb;
         if (bit_r == 3'h7) begin
            case (ph_r)
               smwp_pkg::SMWP_OPC: begin
                  if (nb == `SMWP_OP_STAT_RD)
                     ph_r <= smwp_pkg::SMWP_IDLE; // R18
                  else if (nb == `SMWP_OP_STAT_WR)
                     ph_r <= smwp_pkg::SMWP_STAT;
                  else if (nb == `SMWP_OP_ARRAY_WR || nb == `SMWP_OP_SPARE_WR
                           || nb == `SMWP_OP_SERIAL_WR)
                     ph_r <= smwp_pkg::SMWP_ADDR;
                  else
                     ph_r <= smwp_pkg::SMWP_IDLE;
               end
               smwp_pkg::SMWP_ADDR: begin
                  nab_r <= nab_r + 2'h1;
                  if (nab_r == 2'h2)
                     ph_r <= smwp_pkg::SMWP_DATA;
               end
               smwp_pkg::SMWP_STAT: ph_r <= smwp_pkg::SMWP_IDLE;
               smwp_pkg::SMWP_DATA: begin
                  if (op_r == `SMWP_OP_ARRAY_WR && gprot)
                     stop_r <= 1'b1; // R19
               end
               default: ph_r <= ph_r;
            endcase
         end
      end
   end
   // opcode, address and write strobes; not reset by cs_n so toggles survive
   // sck only runs inside frames, so only rst itself can clear the toggles
   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         op_r <= 8'h00;
         addr_r <= 19'h00000;
         set_tog_r <= 1'b0;
         clr_tog_r <= 1'b0;
         sw_tog_r <= 1'b0;
         sw_data_r <= 3'h0;
         wr_lk_r <= '0;
         wr_tog_r <= 1'b0;
      end else if (!cs_n && bit_r == 3'h7) begin
         if (ph_r == smwp_pkg::SMWP_OPC) begin
            op_r <= nb;
            if (nb == `SMWP_OP_SET_LATCH)
               set_tog_r <= ~set_tog_r; // R02
            if (nb == `SMWP_OP_CLR_LATCH || nb == `SMWP_OP_STAT_WR
                || nb == `SMWP_OP_ARRAY_WR || nb == `SMWP_OP_SPARE_WR
                || nb == `SMWP_OP_SERIAL_WR)
               clr_tog_r <= ~clr_tog_r; // R05 R06
         end
         if (ph_r == smwp_pkg::SMWP_ADDR)
            addr_r <= {addr_r[10:0], nb};
         if (ph_r == smwp_pkg::SMWP_STAT && latch_lk2_r
             && !(pinen_lk2_r && !wp2_r)) begin // R03 R15 R16
            sw_data_r <= {nb[`SMWP_BIT_PIN_EN], nb[`SMWP_BIT_GUARD_HI],
                          nb[`SMWP_BIT_GUARD_LO]}; // R17 R04
            sw_tog_r <= ~sw_tog_r;
         end
         if (ph_r == smwp_pkg::SMWP_DATA && latch_lk2_r && !stop_r
             && !(op_r == `SMWP_OP_ARRAY_WR && gprot)) begin // R03 R14 R20
            wr_lk_r <= '{valid: 1'b1, target: op_r[7:6], addr: addr_r, data: nb};
            wr_tog_r <= ~wr_tog_r;
         end
         if (ph_r == smwp_pkg::SMWP_DATA && !(op_r == `SMWP_OP_ARRAY_WR && gprot)
             && !stop_r)
            addr_r <= addr_r + 19'h1;
      end
   end
   // status read out on falling sck, loaded after the opcode
   assign stat_snap = {pinen_lk2_r, `SMWP_STAT_FIXED >> 6 == 8'h1, 2'b00, grd_lk2_r,
                       latch_lk2_r, 1'b0};
   always_ff @(negedge sck or posedge cs_n) begin
      if (cs_n) begin
         rd_sh_r <= 8'h00;
         so_oe <= 1'b0;
      end else if (ph_r == smwp_pkg::SMWP_IDLE && op_r == `SMWP_OP_STAT_RD) begin
         so_oe <= 1'b1;
         rd_sh_r <= (bit_r == 3'h0) ? stat_snap : {rd_sh_r[6:0], 1'b0}; // R18
      end
   end
   assign so = rd_sh_r[7];

   // system domain: latch and guard bits, fed from toggles
   logic [2:0] set_s_r;
   logic [2:0] clr_s_r;
   logic [2:0] sw_s_r;
   logic [2:0] wr_s_r;
   logic [2:0] cs_s_r;
   logic latch_nxt;
   logic pin_en_nxt;
   logic [1:0] guard_nxt;
   logic nv_store_nxt;
   logic clr_pend_r;
   logic clr_pend_nxt;
   logic loaded_r;
   smwp_pkg::smwp_wr_t wr_req_nxt;
   always_comb begin
      latch_nxt = latch_r;
      clr_pend_nxt = clr_pend_r;
      pin_en_nxt = pin_en_r;
      guard_nxt = guard_r;
      nv_store_nxt = 1'b0;
      wr_req_nxt = '0;
      if (clr_s_r[2] != clr_s_r[1])
         clr_pend_nxt = 1'b1;
      // latch clears at frame end, cs_n rising seen through the sync;
      // a one-byte frame may bring its toggle and its cs_n edge together
      if (cs_s_r[2:1] == 2'b01 && clr_pend_nxt) begin
         latch_nxt = 1'b0; // R05 R06
         clr_pend_nxt = 1'b0;
      end
      if (set_s_r[2] != set_s_r[1])
         latch_nxt = 1'b1; // R02
      if (sw_s_r[2] != sw_s_r[1]) begin
         pin_en_nxt = sw_data_r[2];
         guard_nxt = sw_data_r[1:0]; // R12
         nv_store_nxt = 1'b1;
      end
      if (wr_s_r[2] != wr_s_r[1])
         wr_req_nxt = wr_lk_r;
      if (!loaded_r) begin
         pin_en_nxt = nv_in.pin_en;
         guard_nxt = nv_in.guard; // R12
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         latch_r <= 1'b0; // R01
         clr_pend_r <= 1'b0;
         pin_en_r <= 1'b0;
         guard_r <= 2'b00;
         loaded_r <= 1'b0;
         nv_store <= 1'b0;
         wr_req <= '0;
         set_s_r <= 3'h0;
         clr_s_r <= 3'h0;
         sw_s_r <= 3'h0;
         wr_s_r <= 3'h0;
         cs_s_r <= 3'h7;
      end else begin
         latch_r <= latch_nxt;
         clr_pend_r <= clr_pend_nxt;
         pin_en_r <= pin_en_nxt;
         guard_r <= guard_nxt;
         loaded_r <= 1'b1;
         nv_store <= nv_store_nxt;
         wr_req <= wr_req_nxt;
         set_s_r <= {set_s_r[1:0], set_tog_r};
         clr_s_r <= {clr_s_r[1:0], clr_tog_r};
         sw_s_r <= {sw_s_r[1:0], sw_tog_r};
         wr_s_r <= {wr_s_r[1:0], wr_tog_r};
         cs_s_r <= {cs_s_r[1:0], cs_n};
      end
   end
   assign nv_out = '{pin_en: pin_en_r, guard: guard_r};
   always_ff @(posedge clk) begin
      status <= {pin_en_r, 1'b1, 2'b00, guard_r, latch_r, waking}; // R07 R08 R09 R10 R11
   end

   latch_reset_a: assert property (@(posedge clk) rst |=> !latch_r) // R01
      else $error("latch not clear after reset");
   status_fixed_a: assert property (@(posedge clk) disable iff (rst)
      !$past(rst) |-> status[6] && status[5:4] == 2'b00) // R10
      else $error("fixed status bits wrong");
   status_busy_a: assert property (@(posedge clk) disable iff (rst)
      !waking |=> !status[0]) // R08
      else $error("busy bit set without wake");
   latch_view_a: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> status[1] == $past(latch_r)) // R07
      else $error("latch flag mismatch");
   set_latch_a: assert property (@(posedge clk) disable iff (rst)
      set_s_r[2] != set_s_r[1] |=> latch_r) // R02
      else $error("set command did not set latch");
   clr_latch_a: assert property (@(posedge clk) disable iff (rst)
      cs_s_r[2:1] == 2'b01 && clr_pend_r && set_s_r[2] == set_s_r[1] |=> !latch_r) // R05
      else $error("latch not cleared at frame end");
   guard_hold_a: assert property (@(posedge clk) disable iff (rst)
      loaded_r && sw_s_r[2] == sw_s_r[1] |=> $stable(guard_r)) // R12
      else $error("guard bits changed without write");
   no_write_a: assert property (@(posedge clk) disable iff (rst)
      !latch_r && !$past(latch_r) && wr_s_r[2] == wr_s_r[1] |=> !wr_req.valid) // R03
      else $error("write offered without latch");
   write_latch_a: assert property (@(posedge clk) disable iff (rst)
      wr_s_r[2] != wr_s_r[1] |-> latch_r || $past(latch_r) || $past(latch_r, 2)) // R03
      else $error("write accepted while latch clear");
   so_quiet_a: assert property (@(posedge clk) disable iff (rst)
      so_oe |-> op_r == `SMWP_OP_STAT_RD) // R20
      else $error("serial output driven outside status read");
endmodule
`default_nettype wire

// File: test/smwp_master.sv
// spi bus master model that sends command frames to the core
`default_nettype none
module smwp_master (
   // spi link
   output logic sck,
   output logic cs_n,
   output logic si,
   input wire logic so
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end
   // mode 0: sck stands low outside frames; one opcode per frame
   task automatic xfer(input logic [7:0] q[$], output logic [7:0] rd);
      rd = 8'h00;
      #7 cs_n = 1'b0;
      foreach (q[i]) begin
         for (int b = 7; b >= 0; b--) begin
            si = q[i][b];
            #15 sck = 1'b1;
            rd = {rd[6:0], so};
            #15 sck = 1'b0;
         end
      end
      #15 cs_n = 1'b1;
      // si is not held after the frame
      si = ~si;
      // gap covers the system-side crossing of the frame end
      #400;
   endtask
endmodule
`default_nettype wire

// File: test/smwp_core_tb.sv
// self-checking bench for the spi memory write-protect core
`default_nettype none
module smwp_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b0, wp_n = 1'b1, waking = 1'b0;
   wire logic sck, cs_n, si, so, so_oe, nv_store;
   smwp_pkg::smwp_nv_t nv_in = '0;
   smwp_pkg::smwp_nv_t nv_out;
   smwp_pkg::smwp_wr_t wr_req;
   logic [7:0] status, rd, g;
   logic [1:0] r;
   logic [29:0] exp_q[$];
   int err_total = 0, compares = 0;
   int nv_count = 0;
   always #20 clk = ~clk;
   smwp_core smwp_core_inst (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
      .so(so), .so_oe(so_oe), .wp_n(wp_n), .nv_in(nv_in), .nv_out(nv_out),
      .nv_store(nv_store), .waking(waking), .wr_req(wr_req), .status(status));
   smwp_master smwp_master_inst (.sck(sck), .cs_n(cs_n), .si(si), .so(so));
   task automatic check(input string nm, input logic [29:0] seen, input logic [29:0] ex);
      compares++;
      if (seen !== ex) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, ex, seen);
      end
   endtask
   task automatic results();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic frame(input logic [7:0] q[$]);
      smwp_master_inst.xfer(q, rd);
   endtask
   // waits out the link-to-system crossing before looking
   task automatic stat(input logic [7:0] ex);
      repeat (12) @(posedge clk);
      check("status", 30'(status), 30'(ex));
      check("nv_out", 30'(nv_out), 30'({ex[7], ex[3:2]}));
      check("so_oe", 30'(so_oe), 30'h0);
   endtask
   function automatic logic guarded(input logic [18:0] a, input logic [1:0] gd);
      return gd == 2'b11 || (gd == 2'b10 && a >= 19'h40000) || (gd == 2'b01 && a >= 19'h60000);
   endfunction
   task automatic wr(input logic [7:0] op, input logic [18:0] a, input int n, input logic lt);
      logic [7:0] q[$];
      logic stop;
      stop = ~lt;
      q = {op, 8'(a >> 16), a[15:8], a[7:0]};
      for (int i = 0; i < n; i++) begin
         q.push_back(8'($urandom));
         if (op == 8'h02 && guarded(a, g[3:2]))
            stop = 1'b1;
         if (!stop)
            exp_q.push_back({1'b1, op[7:6], a, q[$]});
         a++;
      end
      frame(q);
   endtask
   always @(posedge clk) begin
      if (nv_store === 1'b1)
         nv_count++;
      if (wr_req.valid === 1'b1) begin
         if (exp_q.size() == 0)
            check("stray write", 30'h1, 30'h0);
         else
            check("write", wr_req[29:0], exp_q.pop_front());
      end
   end
   initial begin
      #1000000;
      err_total++;
      results();
   end
   initial begin
      void'($urandom(99));
      rst <= 1'b1;
      r = 2'($urandom);
      @(posedge clk);
      nv_in <= {1'b0, r};
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      g = {4'h4, r, 2'b00};
      stat(g);
      wr(8'h02, 19'h00100, 2, 1'b0);
      stat(g);
      frame({8'h06});
      stat(g | 8'h02);
      frame({8'h01, 8'h37});
      g = 8'h44;
      stat(g);
      $display("test status fields done");
      for (int k = 0; k < 4; k++) begin
         frame({8'h06});
         frame({8'h01, 8'(k << 2)});
         g = 8'h40 | 8'(k << 2);
         stat(g);
         frame({8'h06});
         wr(8'h02, 19'h3fffe, 3, 1'b1);
         frame({8'h06});
         wr(8'h02, 19'h5ffff, 2, 1'b1);
         stat(g);
      end
      frame({8'h06});
      frame({8'h04});
      stat(g);
      wr(8'h02, 19'h00010, 1, 1'b0);
      $display("test guard ranges done");
      frame({8'h06});
      frame({8'h01, 8'h80});
      g = 8'hc0;
      stat(g);
      @(posedge clk) wp_n <= 1'b0;
      frame({8'h06});
      wr(8'h02, 19'h00010, 1, 1'b1);
      frame({8'h06});
      frame({8'h01, 8'h0c});
      stat(g);
      @(posedge clk) wp_n <= 1'b1;
      frame({8'h06});
      frame({8'h01, 8'h04});
      g = 8'h44;
      stat(g);
      @(posedge clk) wp_n <= 1'b0;
      frame({8'h06});
      frame({8'h01, 8'h00});
      g = 8'h40;
      stat(g);
      @(posedge clk) wp_n <= 1'b1;
      $display("test pin guard done");
      frame({8'h06});
      wr(8'h42, 19'h00012, 2, 1'b1);
      frame({8'h06});
      frame({8'hc2});
      stat(g);
      @(posedge clk) waking <= 1'b1;
      stat(g | 8'h01);
      @(posedge clk) waking <= 1'b0;
      frame({8'h05, 8'h00});
      check("status read", 30'(rd), 30'(g));
      check("pending", 30'(exp_q.size()), 30'h0);
      check("nv stores", 30'(nv_count), 30'h8);
      $display("test side writes done");
      results();
   end
endmodule
`default_nettype wire
